/* logic/power_mode_ctrl.sv */
// Operating-mode power controller with APB register access
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/100ps

// Notes on behaviour
// - Power-up in full-on, PLL unbypassed, clocks on
// - Active: PLL bypassed, clocks at input rate
// - Multiplier written in active applies at full-on
// - Active mode keeps DMA to memory allowed
// - Sleep stops core clock, PLL and system run
// - Sleep wakeup goes by bypass bit
// - No system DMA during sleep
// - Deep sleep: clocks stopped, PLL off, power on
// - Deep sleep blocks asynchronous peripheral accesses
// - Deep sleep ends only on reset, RTC or a zero-volt regulator write
// - RTC interrupt in deep sleep goes active
// - Reset input in deep sleep goes full-on
// - Hibernate: PLL off, clocks stopped, power removed
// - Zero-volt regulator setting enters hibernate
// - Writing 00 drives regulator wake low
// - Each peripheral has its own clock gate
// - Hibernate wakeup runs full reset sequence
// - Regulator wake high means supply on
// - Only regulator control survives hibernate
module power_mode_ctrl (
    input  wire logic                                   sys_clk,
    input  wire logic                                   rst,
    input  wire op_mode_pkg::apb_req_type               apbIn,
    output      op_mode_pkg::apb_rsp_type               apbOut,
    input  wire logic                                   wakeEvent,
    input  wire logic                                   rtcWake,
    input  wire logic                                   resetIn,
    output      op_mode_pkg::power_out_type             powerOut,
    output      logic [op_mode_pkg::NUM_PERIPH-1:0]     periphClkEn
);

    // Registered state and its next value
    op_mode_pkg::ctrl_state_type state_reg;
    op_mode_pkg::ctrl_state_type state_next;

    // Bus phase decode
    logic        setupPhase;   // First cycle of a transfer
    logic        accessFire;   // Access phase completing this edge
    logic        addrHit;      // Address names a register
    logic        writeFire;    // Write taking effect this edge
    // Software requests seen this cycle
    logic        sleepCmd;     // Sleep requested
    logic        deepCmd;      // Deep sleep requested
    logic        offWrite;     // Regulator field written to zero
    logic        hibWake;      // A wake source ends hibernate
    logic [31:0] readValue;    // Read mux output

    // Outputs straight from the state flip-flops
    assign apbOut      = state_reg.rsp;
    assign powerOut    = state_reg.pwr;
    assign periphClkEn = state_reg.periphClkEn;

    // Next state: bus slave, mode sequencer and output table
    always_comb begin
        state_next = state_reg;
        setupPhase = apbIn.psel & ~apbIn.penable;
        accessFire = apbIn.psel & apbIn.penable & state_reg.rsp.pready;
        writeFire  = accessFire & apbIn.pwrite;
        sleepCmd   = 1'b0;
        deepCmd    = 1'b0;
        offWrite   = 1'b0;
        readValue  = 32'h0;

        // Decode the register address
        case (apbIn.paddr)
            op_mode_pkg::PLL_CTRL_OFS: begin
                addrHit = 1'b1;
                readValue[op_mode_pkg::BYPASS_BIT]  = state_reg.bypass;
                readValue[op_mode_pkg::PLL_OFF_BIT] = state_reg.pllOff;
                readValue[op_mode_pkg::MULT_LSB +: op_mode_pkg::MULT_W] =
                    state_reg.pendMult;
            end
            op_mode_pkg::REG_CTRL_OFS: begin
                addrHit = 1'b1;
                readValue[op_mode_pkg::VREG_LSB +: 2]          = state_reg.vreg;
                readValue[op_mode_pkg::RTC_WAKE_EN_BIT] = state_reg.rtcWakeEn;
                readValue[op_mode_pkg::PIN_WAKE_EN_BIT] = state_reg.pinWakeEn;
            end
            op_mode_pkg::MODE_CMD_OFS: begin
                // Write-only command, reads as zero
                addrHit = 1'b1;
            end
            op_mode_pkg::PERIPH_GATE_OFS: begin
                addrHit = 1'b1;
                readValue[op_mode_pkg::NUM_PERIPH-1:0] = state_reg.periphGate;
            end
            op_mode_pkg::STATUS_OFS: begin
                // Live mode, applied multiplier and control outputs
                addrHit          = 1'b1;
                readValue[2:0]   = state_reg.mode;
                readValue[8:3]   = state_reg.appliedMult;
                readValue[17:9]  = state_reg.pwr;
            end
            default: begin
                // Unmapped: error answer, no effect
                addrHit = 1'b0;
            end
        endcase

        // Zero-wait answer: ready in the first access cycle
        state_next.rsp.pready  = setupPhase;
        state_next.rsp.pslverr = setupPhase & ~addrHit;
        state_next.rsp.prdata  = setupPhase ? readValue : 32'h0;

        // Register writes at the completing access edge
        if (writeFire) begin
            case (apbIn.paddr)
                op_mode_pkg::PLL_CTRL_OFS: begin
                    state_next.bypass   = apbIn.pwdata[op_mode_pkg::BYPASS_BIT];
                    // PLL may only be switched off in active mode
                    state_next.pllOff   = apbIn.pwdata[op_mode_pkg::PLL_OFF_BIT] &
                        (state_reg.mode == op_mode_pkg::ACTIVE);
                    // Held pending until full-on is entered
                    state_next.pendMult =
                        apbIn.pwdata[op_mode_pkg::MULT_LSB +: op_mode_pkg::MULT_W];
                end
                op_mode_pkg::REG_CTRL_OFS: begin
                    state_next.vreg      = apbIn.pwdata[op_mode_pkg::VREG_LSB +: 2];
                    state_next.rtcWakeEn = apbIn.pwdata[op_mode_pkg::RTC_WAKE_EN_BIT];
                    state_next.pinWakeEn = apbIn.pwdata[op_mode_pkg::PIN_WAKE_EN_BIT];
                    offWrite = apbIn.pwdata[op_mode_pkg::VREG_LSB +: 2] ==
                        op_mode_pkg::VREG_OFF;
                end
                op_mode_pkg::MODE_CMD_OFS: begin
                    sleepCmd = apbIn.pwdata[1:0] == op_mode_pkg::CMD_SLEEP;
                    deepCmd  = apbIn.pwdata[1:0] == op_mode_pkg::CMD_DEEP;
                end
                op_mode_pkg::PERIPH_GATE_OFS: begin
                    state_next.periphGate = apbIn.pwdata[op_mode_pkg::NUM_PERIPH-1:0];
                end
                default: begin
                    // Nothing stored
                    state_next.periphGate = state_reg.periphGate;
                end
            endcase
        end

        // Any enabled source wakes the device out of hibernate
        hibWake = resetIn | (rtcWake & state_reg.rtcWakeEn) |
                  (wakeEvent & state_reg.pinWakeEn);

        // Mode sequencer
        state_next.pwr.resetSeq = 1'b0;
        if (state_reg.mode == op_mode_pkg::HIBERNATE) begin
            if (hibWake) begin
                // Fresh reset; regulator control contents survive
                state_next           = op_mode_pkg::RESET_STATE;
                state_next.vreg      = state_reg.vreg;
                state_next.rtcWakeEn = state_reg.rtcWakeEn;
                state_next.pinWakeEn = state_reg.pinWakeEn;
                state_next.pwr.resetSeq = 1'b1;
            end
        end else if (offWrite) begin
            // Zero-volt request: go straight to hibernate
            state_next.mode = op_mode_pkg::HIBERNATE;
        end else if (resetIn) begin
            // Reset input returns to full-on from any running mode
            state_next = op_mode_pkg::RESET_STATE;
            state_next.vreg      = state_reg.vreg;
            state_next.rtcWakeEn = state_reg.rtcWakeEn;
            state_next.pinWakeEn = state_reg.pinWakeEn;
            state_next.pwr.resetSeq = 1'b1;
        end else begin
            case (state_reg.mode)
                op_mode_pkg::FULL_ON: begin
                    if (state_next.bypass) begin
                        // Bypass set: move to active through a gated cycle
                        state_next.mode     = op_mode_pkg::SWITCHING;
                        state_next.toFullOn = 1'b0;
                    end else if (sleepCmd) begin
                        state_next.mode = op_mode_pkg::SLEEP;
                    end else if (deepCmd) begin
                        state_next.mode = op_mode_pkg::DEEP_SLEEP;
                    end
                end
                op_mode_pkg::ACTIVE: begin
                    if (!state_next.bypass && !state_next.pllOff) begin
                        // Unbypass only with the PLL running
                        state_next.mode     = op_mode_pkg::SWITCHING;
                        state_next.toFullOn = 1'b1;
                    end else if (sleepCmd && !state_reg.pllOff) begin
                        state_next.mode = op_mode_pkg::SLEEP;
                    end else if (deepCmd) begin
                        state_next.mode = op_mode_pkg::DEEP_SLEEP;
                    end
                end
                op_mode_pkg::SLEEP: begin
                    if (wakeEvent || rtcWake) begin
                        // Bypass bit picks the target mode
                        state_next.mode     = op_mode_pkg::SWITCHING;
                        state_next.toFullOn = ~state_reg.bypass;
                    end
                end
                op_mode_pkg::DEEP_SLEEP: begin
                    // Only the RTC interrupt, reset or a zero-volt regulator write ends deep sleep
                    if (rtcWake) begin
                        state_next.mode     = op_mode_pkg::SWITCHING;
                        state_next.toFullOn = 1'b0;
                        state_next.bypass   = 1'b1;
                    end
                end
                op_mode_pkg::SWITCHING: begin
                    // Clocks were gated last cycle; now release
                    state_next.mode = state_reg.toFullOn ?
                        op_mode_pkg::FULL_ON : op_mode_pkg::ACTIVE;
                end
                default: begin
                    state_next.mode = op_mode_pkg::FULL_ON;
                end
            endcase
        end

        // New multiplier takes effect on entry to full-on
        if (state_next.mode == op_mode_pkg::FULL_ON &&
            state_reg.mode != op_mode_pkg::FULL_ON) begin
            state_next.appliedMult = state_next.pendMult;
        end

        // Output table per mode
        case (state_next.mode)
            op_mode_pkg::FULL_ON: begin
                state_next.pwr.pllEnable   = 1'b1;
                state_next.pwr.pllBypass   = 1'b0;
                state_next.pwr.coreClockEn = 1'b1;
                state_next.pwr.sysClockEn  = 1'b1;
                state_next.pwr.corePowerOn = 1'b1;
                state_next.pwr.dmaAllow    = 1'b1;
                state_next.pwr.asyncBlock  = 1'b0;
            end
            op_mode_pkg::ACTIVE: begin
                state_next.pwr.pllEnable   = ~state_next.pllOff;
                state_next.pwr.pllBypass   = 1'b1;
                state_next.pwr.coreClockEn = 1'b1;
                state_next.pwr.sysClockEn  = 1'b1;
                state_next.pwr.corePowerOn = 1'b1;
                state_next.pwr.dmaAllow    = 1'b1;
                state_next.pwr.asyncBlock  = 1'b0;
            end
            op_mode_pkg::SLEEP: begin
                // Bypass select held as it was
                state_next.pwr.pllEnable   = 1'b1;
                state_next.pwr.coreClockEn = 1'b0;
                state_next.pwr.sysClockEn  = 1'b1;
                state_next.pwr.corePowerOn = 1'b1;
                state_next.pwr.dmaAllow    = 1'b0;
                state_next.pwr.asyncBlock  = 1'b0;
            end
            op_mode_pkg::DEEP_SLEEP: begin
                state_next.pwr.pllEnable   = 1'b0;
                state_next.pwr.coreClockEn = 1'b0;
                state_next.pwr.sysClockEn  = 1'b0;
                state_next.pwr.corePowerOn = 1'b1;
                state_next.pwr.dmaAllow    = 1'b0;
                state_next.pwr.asyncBlock  = 1'b1;
            end
            op_mode_pkg::HIBERNATE: begin
                state_next.pwr.pllEnable   = 1'b0;
                state_next.pwr.coreClockEn = 1'b0;
                state_next.pwr.sysClockEn  = 1'b0;
                state_next.pwr.corePowerOn = 1'b0;
                state_next.pwr.dmaAllow    = 1'b0;
                state_next.pwr.asyncBlock  = 1'b1;
            end
            default: begin
                // Switching: both clocks held off while bypass moves
                state_next.pwr.pllEnable   = state_next.toFullOn | ~state_next.pllOff;
                state_next.pwr.pllBypass   = ~state_next.toFullOn;
                state_next.pwr.coreClockEn = 1'b0;
                state_next.pwr.sysClockEn  = 1'b0;
                state_next.pwr.corePowerOn = 1'b1;
                state_next.pwr.dmaAllow    = 1'b0;
                state_next.pwr.asyncBlock  = 1'b0;
            end
        endcase

        // Regulator wake: low after a zero write, high again on wake
        if (offWrite && state_reg.mode != op_mode_pkg::HIBERNATE) begin
            state_next.pwr.regulatorWakeOut = 1'b0;
        end else if (state_next.pwr.resetSeq) begin
            state_next.pwr.regulatorWakeOut = 1'b1;
        end

        // Per-peripheral gates, all off with the system clock
        state_next.periphClkEn = state_next.periphGate &
            {op_mode_pkg::NUM_PERIPH{state_next.pwr.sysClockEn}};
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= op_mode_pkg::RESET_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : power_mode_ctrl

/* logic/op_mode_pkg.sv */
// Constants and types for the operating-mode power controller
package op_mode_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] PLL_CTRL_OFS    = 8'h00;
    localparam logic [7:0] REG_CTRL_OFS    = 8'h04;
    localparam logic [7:0] MODE_CMD_OFS    = 8'h08;
    localparam logic [7:0] PERIPH_GATE_OFS = 8'h0c;
    localparam logic [7:0] STATUS_OFS      = 8'h10;

    // Field positions in pll_control_reg
    localparam int BYPASS_BIT  = 0;
    localparam int PLL_OFF_BIT = 1;
    localparam int MULT_LSB    = 2;
    localparam int MULT_W      = 6;

    // Field positions in regulator_control_reg
    localparam int VREG_LSB        = 0;
    localparam int RTC_WAKE_EN_BIT = 2;
    localparam int PIN_WAKE_EN_BIT = 3;

    // Mode command codes and special field values
    localparam logic [1:0] CMD_SLEEP = 2'h1;
    localparam logic [1:0] CMD_DEEP  = 2'h2;
    localparam logic [1:0] VREG_OFF  = 2'h0;

    // Peripheral count and reset values
    localparam int                NUM_PERIPH        = 16;
    localparam logic [MULT_W-1:0] MULT_RESET        = 6'h05;
    localparam logic [1:0]        VREG_RESET        = 2'h3;
    localparam logic [15:0]       PERIPH_GATE_RESET = 16'hffff;

    // Operating modes plus a transient state that gates clocks
    typedef enum logic [2:0] {
        FULL_ON, ACTIVE, SLEEP, DEEP_SLEEP, HIBERNATE, SWITCHING
    } mode_type;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    // APB answer to the master
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_type;

    // Power and clock controls toward the chip
    typedef struct packed {
        logic pllEnable;
        logic pllBypass;
        logic coreClockEn;
        logic sysClockEn;
        logic corePowerOn;
        logic dmaAllow;
        logic asyncBlock;
        logic regulatorWakeOut;
        logic resetSeq;
    } power_out_type;

    // Whole controller state
    typedef struct packed {
        mode_type                mode;
        logic                    toFullOn;
        logic                    bypass;
        logic                    pllOff;
        logic [MULT_W-1:0]       appliedMult;
        logic [MULT_W-1:0]       pendMult;
        logic [1:0]              vreg;
        logic                    rtcWakeEn;
        logic                    pinWakeEn;
        logic [NUM_PERIPH-1:0]   periphGate;
        logic [NUM_PERIPH-1:0]   periphClkEn;
        apb_rsp_type             rsp;
        power_out_type           pwr;
    } ctrl_state_type;

    // Power-up state: full-on, PLL running unbypassed, clocks on
    localparam ctrl_state_type RESET_STATE = '{
        mode: FULL_ON, toFullOn: 1'b0, bypass: 1'b0, pllOff: 1'b0,
        appliedMult: MULT_RESET, pendMult: MULT_RESET, vreg: VREG_RESET,
        rtcWakeEn: 1'b1, pinWakeEn: 1'b1,
        periphGate: PERIPH_GATE_RESET, periphClkEn: PERIPH_GATE_RESET,
        rsp: '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0},
        pwr: '{pllEnable: 1'b1, pllBypass: 1'b0, coreClockEn: 1'b1,
               sysClockEn: 1'b1, corePowerOn: 1'b1, dmaAllow: 1'b1,
               asyncBlock: 1'b0, regulatorWakeOut: 1'b1, resetSeq: 1'b0}
    };

endpackage : op_mode_pkg

/* verif/far_side_model.sv */
// Far side: core supply regulator and wakeup sources
`timescale 1ns/100ps
module far_side_model (
    input  wire logic sys_clk,   // Clock
    input  wire logic rst,       // Async reset
    input  wire logic wakeOut,   // Supply request
    input  wire logic rtcReq,    // Bench asks for clock interrupt
    input  wire logic extReq,    // Bench asks for wakeup
    input  wire logic slow,      // Answer three cycles late
    output      logic rtcWake,   // Clock interrupt line
    output      logic wakeEvent, // Wakeup line
    output      logic supplyOn   // Core supply state
);
    logic [3:0] rtc_reg; // Interrupt delay line
    logic [3:0] ext_reg; // Wakeup delay line
    // Delay lines; regulator follows its request
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rtc_reg  <= 4'h0;
            ext_reg  <= 4'h0;
            supplyOn <= 1'b1;
        end else begin
            rtc_reg  <= {rtc_reg[2:0], rtcReq};
            ext_reg  <= {ext_reg[2:0], extReq};
            supplyOn <= wakeOut;
        end
    end
    // Prompt or late tap
    assign rtcWake   = slow ? rtc_reg[3] : rtc_reg[0];
    assign wakeEvent = slow ? ext_reg[3] : ext_reg[0];
endmodule : far_side_model

/* verif/power_mode_monitor.sv */
// Checker of power controls against their causes
`timescale 1ns/100ps
module power_mode_monitor (
    input wire logic                               sys_clk,
    input wire logic                               rst,
    input wire op_mode_pkg::apb_req_type           apbIn,
    input wire op_mode_pkg::apb_rsp_type           apbOut,
    input wire logic                               wakeEvent,
    input wire logic                               rtcWake,
    input wire logic                               resetIn,
    input wire op_mode_pkg::power_out_type         powerOut,
    input wire logic [op_mode_pkg::NUM_PERIPH-1:0] periphClkEn
);
    wire op_mode_pkg::power_out_type p = powerOut;  // Short name
    wire deep = p.asyncBlock && p.corePowerOn;     // Deep sleep seen
    // Write of zero-volt setting at its access edge
    wire offWr = apbIn.psel && apbIn.penable && apbOut.pready && apbIn.pwrite
        && apbIn.paddr == op_mode_pkg::REG_CTRL_OFS && apbIn.pwdata[1:0] == 2'h0;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sleep_clocks_a: assert property (p.sysClockEn && !p.coreClockEn
        |-> p.pllEnable && !p.dmaAllow) else $error("sleep controls wrong");
    deep_block_a: assert property (p.asyncBlock
        |-> !p.coreClockEn && !p.sysClockEn && !p.pllEnable) else $error("deep wrong");
    hib_power_a: assert property (!p.corePowerOn |-> !p.pllEnable
        && !p.coreClockEn && !p.sysClockEn && !p.regulatorWakeOut) else $error("hib");
    regulator_switch_field_a_off_a: assert property (offWr
        |-> ##[1:2] (!p.regulatorWakeOut && !p.corePowerOn)) else $error("no shutdown");
    active_dma_a: assert property (p.pllBypass && p.coreClockEn
        |-> p.sysClockEn && p.dmaAllow) else $error("active controls wrong");
    deep_hold_a: assert property (deep && !rtcWake && !$past(rtcWake)
        && !resetIn && !$past(resetIn) && !apbIn.psel |=> p.asyncBlock)
        else $error("deep sleep left");
    rtc_deep_a: assert property (deep && rtcWake && !resetIn
        |-> ##[1:3] (p.pllBypass && p.coreClockEn)) else $error("no active");
    reset_full_a: assert property ($rose(resetIn) && p.corePowerOn
        |-> ##[1:2] (p.resetSeq && p.pllEnable && !p.pllBypass)) else $error("reset");
    bypass_glitch_a: assert property ($changed(p.pllBypass) && $past(p.coreClockEn)
        && !p.resetSeq |-> !p.coreClockEn && !p.sysClockEn) else $error("glitch");
    // Main scenarios
    cover property (deep && rtcWake);
    cover property (offWr);
    cover property (p.resetSeq);
endmodule : power_mode_monitor
bind power_mode_ctrl power_mode_monitor power_mode_monitor_i (.sys_clk, .rst,
    .apbIn, .apbOut, .wakeEvent, .rtcWake, .resetIn, .powerOut, .periphClkEn);

/* verif/testbench.sv */
// Self-checking bench for the power controller
`timescale 1ns/100ps
module testbench;
    logic                       sys_clk;     // Clock
    logic                       rst;         // Reset
    op_mode_pkg::apb_req_type   apbIn;       // Bus request
    op_mode_pkg::apb_rsp_type   apbOut;      // Bus answer
    logic                       wakeEvent;   // Wakeup line
    logic                       rtcWake;     // Clock interrupt
    logic                       resetIn;     // Reset input
    op_mode_pkg::power_out_type powerOut;    // Power controls
    logic [15:0]                periphClkEn; // Gated clocks
    logic                       rtcReq;      // Far-side requests
    logic                       extReq;
    logic                       slow;        // Late answers
    logic                       supplyOn;    // Regulator state
    logic [31:0]                q;           // Read data
    logic [31:0]                v;           // Random value
    logic [5:0]                 m;           // Random multiplier
    int                         fails;       // Mismatches
    int                         numChecks;   // Comparisons
    int                         cycles;      // Timeout count
    int                         seed;        // Random seed
    power_mode_ctrl power_mode_ctrl_i (.sys_clk, .rst, .apbIn, .apbOut, .wakeEvent,
        .rtcWake, .resetIn, .powerOut, .periphClkEn);
    far_side_model far_side_model_i (.sys_clk, .rst, .wakeOut(powerOut.regulatorWakeOut),
        .rtcReq, .extReq, .slow, .rtcWake, .wakeEvent, .supplyOn);
    // Clock of 100 ns period
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Compare masked power controls
    task automatic chkp(input logic [8:0] mask, input logic [8:0] exp);
        check(32'(powerOut & mask), 32'(exp & mask));
    endtask : chkp
    // Expected gated clocks
    function automatic logic [15:0] gateExp(input logic [15:0] g, input logic on);
        return g & {16{on}};
    endfunction : gateExp
    // Bus transfer: setup, access held until ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        apbIn <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge sys_clk);
        apbIn.penable <= 1'b1;
        do @(posedge sys_clk); while (apbOut.pready !== 1'b1);
        check(apbOut.pready, 32'h1);
        q = apbOut.pslverr ? 32'hdead : apbOut.prdata;
        apbIn.psel <= 1'b0;
        apbIn.penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    // Let a mode change finish
    task automatic pause;
        repeat (3) @(posedge sys_clk);
    endtask : pause
    // Ask the far side for a wakeup
    task automatic pulse(input logic rtc, input logic late);
        slow <= late;
        rtcReq <= rtc;
        extReq <= !rtc;
        @(posedge sys_clk);
        rtcReq <= 1'b0;
        extReq <= 1'b0;
    endtask : pulse
    // Counts and verdict
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            report_and_stop();
        end
    end
    // Main sequence
    initial begin
        {fails, numChecks, cycles} = '0;
        seed = 32'hdf3f;
        {rst, apbIn, resetIn, rtcReq, extReq, slow} = '0;
        rst = 1'b1;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chkp(9'h1ff, 9'h17a);
        check(periphClkEn, 32'hffff);
        apb(1'b0, op_mode_pkg::STATUS_OFS, 32'h0);
        check(q[8:0], {op_mode_pkg::MULT_RESET, op_mode_pkg::FULL_ON});
        apb(1'b0, 8'h20, 32'h0);
        check(q, 32'hdead);
        $display("reset test done");
        // Random peripheral gates
        repeat (3) begin
            v = $random(seed);
            apb(1'b1, op_mode_pkg::PERIPH_GATE_OFS, {16'h0, v[15:0]});
            pause();
            check(periphClkEn, gateExp(v[15:0], 1'b1));
        end
        $display("gating test done");
        // Bypass, pending ratio, PLL off in active
        m = 6'($random(seed)) | 6'h20;
        apb(1'b1, op_mode_pkg::PLL_CTRL_OFS, 32'h15);
        pause();
        chkp(9'h1ff, 9'h1fa);
        apb(1'b1, op_mode_pkg::PLL_CTRL_OFS, {24'h0, m, 2'h3});
        pause();
        chkp(9'h1ff, 9'h0fa);
        apb(1'b0, op_mode_pkg::STATUS_OFS, 32'h0);
        check(q[8:3], op_mode_pkg::MULT_RESET);
        apb(1'b1, op_mode_pkg::PLL_CTRL_OFS, {24'h0, m, 2'h1});
        apb(1'b1, op_mode_pkg::PLL_CTRL_OFS, {24'h0, m, 2'h0});
        pause();
        apb(1'b0, op_mode_pkg::STATUS_OFS, 32'h0);
        check(q[8:0], {m, op_mode_pkg::FULL_ON});
        $display("active test done");
        // Sleep and wake by bypass choice
        for (int b = 0; b < 2; b++) begin
            apb(1'b1, op_mode_pkg::PLL_CTRL_OFS, {24'h0, m, 1'b0, b[0]});
            pause();
            apb(1'b1, op_mode_pkg::MODE_CMD_OFS, {30'h0, op_mode_pkg::CMD_SLEEP});
            pause();
            chkp(9'h17a, 9'h132);
            pulse(1'b0, b[0]);
            repeat (20) if (powerOut.coreClockEn !== 1'b1) @(posedge sys_clk);
            pause();
            apb(1'b0, op_mode_pkg::STATUS_OFS, 32'h0);
            check(q[2:0], b[2:0]);
        end
        $display("sleep test done");
        // Deep sleep: wakeup ignored, clock interrupt, reset input
        apb(1'b1, op_mode_pkg::MODE_CMD_OFS, {30'h0, op_mode_pkg::CMD_DEEP});
        pause();
        chkp(9'h176, 9'h016);
        pulse(1'b0, 1'b0);
        pause();
        chkp(9'h176, 9'h016);
        pulse(1'b1, 1'b0);
        repeat (20) if (powerOut.coreClockEn !== 1'b1) @(posedge sys_clk);
        pause();
        apb(1'b0, op_mode_pkg::STATUS_OFS, 32'h0);
        check(q[2:0], op_mode_pkg::ACTIVE);
        apb(1'b1, op_mode_pkg::MODE_CMD_OFS, {30'h0, op_mode_pkg::CMD_DEEP});
        pause();
        resetIn <= 1'b1;
        @(posedge sys_clk);
        resetIn <= 1'b0;
        pause();
        chkp(9'h1ff, 9'h17a);
        $display("deep sleep test done");
        // Hibernate, after software saves its settings
        apb(1'b0, op_mode_pkg::PLL_CTRL_OFS, 32'h0);
        apb(1'b1, op_mode_pkg::PERIPH_GATE_OFS, 32'h00ff);
        apb(1'b1, op_mode_pkg::REG_CTRL_OFS, 32'h4);
        pause();
        chkp(9'h172, 9'h000);
        check(supplyOn, 32'h0);
        check(periphClkEn, gateExp(16'h00ff, 1'b0));
        pulse(1'b0, 1'b0);
        pause();
        chkp(9'h172, 9'h000);
        pulse(1'b1, 1'b1);
        repeat (20) if (powerOut.corePowerOn !== 1'b1) @(posedge sys_clk);
        pause();
        chkp(9'h1ff, 9'h17a);
        check(supplyOn, 32'h1);
        check(periphClkEn, 32'hffff);
        apb(1'b0, op_mode_pkg::REG_CTRL_OFS, 32'h0);
        check(q[3:0], 4'h4);
        apb(1'b0, op_mode_pkg::PLL_CTRL_OFS, 32'h0);
        check(q[7:0], {op_mode_pkg::MULT_RESET, 2'h0});
        $display("hibernate test done");
        report_and_stop();
    end
endmodule : testbench
